// >>> spi_param_defs.svh
`ifndef SPI_PARAM_DEFS_SVH
`define SPI_PARAM_DEFS_SVH

// Command opcodes.
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99
`define OP_PARAM_READ 8'h5A

// Frame layout in serial clocks.
`define OPCODE_LAST_BIT 5'd7
`define ADDR_LAST_BIT 5'd23
`define DUMMY_LAST_CLK 5'd7

// Reset recovery time and its cycle count at the system clock rate.
`define T_RST_RECOVER_NS 30000
`define SYS_CLK_PERIOD_NS 50
`define RST_RECOVER_CYCLES \
    ((`T_RST_RECOVER_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

// Register byte offsets.
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_VOLATILE 4'h8

// Field positions.
`define CTRL_SOFT_RESET_BIT 0
`define STATUS_RECOVER_BIT 0
`define STATUS_ARMED_BIT 1
`define STATUS_READING_BIT 2
`define STATUS_OP_BUSY_BIT 3
`define STATUS_COUNT_LSB 8
`define STATUS_COUNT_MSB 15
`define VOLATILE_MSB 20

// Reset values.
`define VOLATILE_RESET 21'h0_0000
`define READDATA_RESET 32'h0000_0000
`define RESET_COUNT_RESET 8'h00

// Vendor identification byte; the value is arbitrary.
`define VENDOR_ID_DEFAULT 8'h5A

`endif

// >>> flash_types_pkg.sv
package flash_types_pkg;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_opcode = 3'b001,
        st_addr = 3'b011,
        st_dummy = 3'b010,
        st_data = 3'b110,
        st_ignore = 3'b111
    } frame_state_e;

    typedef struct packed {
        logic suspend_flag;
        logic write_enable_latch;
        logic [2:0] wrap_setting_field;
        logic [7:0] continuous_read_field;
        logic [7:0] read_parameter_field;
    } volatile_s;

endpackage

// >>> param_table_rom.sv
`timescale 1ns/1ps
module param_table_rom #(
    // The default vendor byte is arbitrary.
    parameter logic [7:0] VENDOR_ID = 8'h5A
) (
    input wire logic [23:0] table_addr,
    output logic [7:0] table_byte
);
    // Anything outside the populated bytes, including the vendor table,
    // reads as erased flash.
    always_comb begin
        table_byte = 8'hFF;
        if (table_addr[23:8] == 16'h0000) begin
            case (table_addr[7:0])
                8'h00: table_byte = 8'h53;
                8'h01: table_byte = 8'h46;
                8'h02: table_byte = 8'h44;
                8'h03: table_byte = 8'h50;
                8'h04: table_byte = 8'h00;
                8'h05: table_byte = 8'h01;
                8'h06: table_byte = 8'h01;
                8'h08: table_byte = 8'h00;
                8'h09: table_byte = 8'h00;
                8'h0A: table_byte = 8'h01;
                8'h0B: table_byte = 8'h09;
                8'h0C: table_byte = 8'h30;
                8'h0D: table_byte = 8'h00;
                8'h0E: table_byte = 8'h00;
                8'h10: table_byte = VENDOR_ID;
                8'h11: table_byte = 8'h00;
                8'h12: table_byte = 8'h01;
                8'h13: table_byte = 8'h03;
                8'h14: table_byte = 8'h60;
                8'h15: table_byte = 8'h00;
                8'h16: table_byte = 8'h00;
                8'h30: table_byte = 8'hE5;
                8'h31: table_byte = 8'h20;
                8'h32: table_byte = 8'hF1;
                8'h36: table_byte = 8'h3F;
                8'h37: table_byte = 8'h00;
                8'h38: table_byte = 8'h44;
                8'h39: table_byte = 8'hEB;
                8'h3A: table_byte = 8'h08;
                8'h3B: table_byte = 8'h6B;
                8'h3C: table_byte = 8'h08;
                8'h3D: table_byte = 8'h3B;
                8'h3E: table_byte = 8'h42;
                8'h3F: table_byte = 8'hBB;
                8'h40: table_byte = 8'hEE;
                8'h46: table_byte = 8'h00;
                8'h4A: table_byte = 8'h00;
                8'h4C: table_byte = 8'h0C;
                8'h4D: table_byte = 8'h20;
                8'h4E: table_byte = 8'h0F;
                8'h4F: table_byte = 8'h52;
                8'h50: table_byte = 8'h10;
                8'h51: table_byte = 8'hD8;
                8'h52: table_byte = 8'h00;
                default: table_byte = 8'hFF;
            endcase
        end
    end
endmodule

// >>> serial_flash_reset_and_param_table.sv
// Operation
// - An accepted reset aborts internal work and clears all volatile state.
// - During reset recovery every incoming command is ignored.
// - Opcode 5Ah returns parameter table bytes from the given address.
// - Bytes 00h-06h hold signature, revision 1.0 and one extra header.
// - Bytes 07h, 0Fh and 17h always read FFh.
// - First header: ID 00h, rev 1.0, 9 dwords, pointer 000030h.
// - Second header: vendor ID, rev 1.0, 3 dwords, pointer 000060h.
// - Byte 30h reads E5h.
// - Byte 30h bits 1:0 are 01b; byte 31h holds erase opcode 20h.
// - Byte 32h reads F1h.
// - Bytes 38h, 39h read 44h and EBh.
// - Bytes 3Ah, 3Bh read 08h and 6Bh.
`timescale 1ns/1ps
`include "spi_param_defs.svh"
module serial_flash_reset_and_param_table
    import flash_types_pkg::*;
#(
    parameter int RST_CYCLES = `RST_RECOVER_CYCLES,
    parameter logic [7:0] VENDOR_ID = `VENDOR_ID_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe_n,
    input wire logic op_busy,
    output logic op_abort,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // Recovery must last at least as long as the eight-cycle hold that the checks rely on.
    if (RST_CYCLES < 8 || RST_CYCLES > 65535) begin : g_check
        $error("RST_CYCLES must lie in 8 to 65535");
    end

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // Pins are sampled through two flops; the third stage only delays the
    // second for edge detection. The serial clock must stay below one
    // eighth of the system clock so that every edge is seen.
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [1:0] si_sync;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_low;
    logic si_bit;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sclk_sync <= 3'h0;
            cs_sync <= 3'h7;
            si_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], spi_sclk};
            cs_sync <= {cs_sync[1:0], spi_cs_n};
            si_sync <= {si_sync[0], spi_si};
        end
    end

    assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    assign cs_rise = cs_sync[1] & ~cs_sync[2];
    assign cs_low = ~cs_sync[1];
    assign si_bit = si_sync[1];

    frame_state_e state;
    frame_state_e next_state;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] next_shift_in;
    logic [7:0] opcode;
    logic [7:0] next_opcode;
    logic op_done;
    logic next_op_done;
    logic extra_clk;
    logic next_extra_clk;
    logic [23:0] tbl_addr;
    logic [23:0] next_tbl_addr;
    logic [2:0] out_cnt;
    logic [2:0] next_out_cnt;
    logic next_spi_so;
    logic next_spi_so_oe_n;
    logic [7:0] table_byte;
    logic recover_busy;
    wire logic out_bit = table_byte[3'd7 - out_cnt];

    param_table_rom #(
        .VENDOR_ID(VENDOR_ID)
    ) param_table_rom_inst (
        .table_addr(tbl_addr),
        .table_byte(table_byte)
    );

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_opcode = opcode;
        next_op_done = op_done;
        next_extra_clk = extra_clk;
        next_tbl_addr = tbl_addr;
        next_out_cnt = out_cnt;
        next_spi_so = spi_so;
        next_spi_so_oe_n = spi_so_oe_n;
        if (!cs_low) begin
            next_state = st_idle;
            next_spi_so_oe_n = 1'b1;
        end else begin
            case (state)
                st_idle: begin
                    next_state = st_opcode;
                    next_bit_cnt = 5'd0;
                    next_op_done = 1'b0;
                    next_extra_clk = 1'b0;
                end
                st_opcode: begin
                    if (sclk_rise) begin
                        next_shift_in = {shift_in[6:0], si_bit};
                        next_bit_cnt = bit_cnt + 5'd1;
                        if (bit_cnt == `OPCODE_LAST_BIT) begin
                            next_opcode = {shift_in[6:0], si_bit};
                            next_op_done = 1'b1;
                            next_bit_cnt = 5'd0;
                            if (recover_busy) begin
                                next_state = st_ignore;
                            end else if ({shift_in[6:0], si_bit} ==
                                         `OP_PARAM_READ) begin
                                next_state = st_addr;
                            end else begin
                                next_state = st_ignore;
                            end
                        end
                    end
                end
                st_addr: begin
                    if (sclk_rise) begin
                        next_tbl_addr = {tbl_addr[22:0], si_bit};
                        next_bit_cnt = bit_cnt + 5'd1;
                        if (bit_cnt == `ADDR_LAST_BIT) begin
                            next_state = st_dummy;
                            next_bit_cnt = 5'd0;
                        end
                    end
                end
                st_dummy: begin
                    if (sclk_rise) begin
                        next_bit_cnt = bit_cnt + 5'd1;
                        if (bit_cnt == `DUMMY_LAST_CLK) begin
                            next_state = st_data;
                            next_out_cnt = 3'd0;
                        end
                    end
                end
                st_data: begin
                    // Bits leave MSB first on falling edges; the address
                    // steps once the last bit of a byte is out.
                    if (sclk_fall) begin
                        next_spi_so = out_bit;
                        next_spi_so_oe_n = 1'b0;
                        next_out_cnt = out_cnt + 3'd1;
                        if (out_cnt == 3'd7) begin
                            next_tbl_addr = tbl_addr + 24'h00_0001;
                        end
                    end
                end
                default: begin
                    if (sclk_rise) begin
                        next_extra_clk = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= st_idle;
            bit_cnt <= 5'd0;
            shift_in <= 8'h00;
            opcode <= 8'h00;
            op_done <= 1'b0;
            extra_clk <= 1'b0;
            tbl_addr <= 24'h00_0000;
            out_cnt <= 3'd0;
            spi_so <= 1'b0;
            spi_so_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            opcode <= next_opcode;
            op_done <= next_op_done;
            extra_clk <= next_extra_clk;
            tbl_addr <= next_tbl_addr;
            out_cnt <= next_out_cnt;
            spi_so <= next_spi_so;
            spi_so_oe_n <= next_spi_so_oe_n;
        end
    end

    // Reset sequencing. A frame is clean when exactly eight clocks carried
    // its opcode; any frame that clocked bits and is not a clean enable
    // cancels a pending enable.
    logic armed;
    logic next_armed;
    logic [15:0] recover_cnt;
    logic [15:0] next_recover_cnt;
    logic [7:0] reset_count;
    logic [7:0] next_reset_count;
    logic next_op_abort;
    logic clean_frame;
    logic spi_reset_go;
    logic soft_reset_go;
    logic reset_go;
    volatile_s vol;
    volatile_s next_vol;

    assign recover_busy = recover_cnt != 16'h0000;
    assign clean_frame = op_done & ~extra_clk & (state == st_ignore);
    assign spi_reset_go = cs_rise & clean_frame & armed & ~recover_busy &
        (opcode == `OP_RESET);
    assign soft_reset_go = avs_write & ~avs_waitrequest &
        (avs_address == `REG_CTRL) & avs_writedata[`CTRL_SOFT_RESET_BIT];
    assign reset_go = spi_reset_go | soft_reset_go;

    always_comb begin
        next_armed = armed;
        next_recover_cnt = recover_cnt;
        next_reset_count = reset_count;
        next_op_abort = reset_go;
        next_vol = vol;
        if (recover_busy || reset_go) begin
            next_armed = 1'b0;
        end else if (cs_rise && (op_done || bit_cnt != 5'd0)) begin
            next_armed = clean_frame &&
                (opcode == `OP_RESET_ENABLE);
        end
        if (reset_go) begin
            next_recover_cnt = 16'(RST_CYCLES);
            next_reset_count = reset_count + 8'h01;
        end else if (recover_busy) begin
            next_recover_cnt = recover_cnt - 16'h0001;
        end
        // The hardware reset wins over a software write in the same cycle.
        if (reset_go) begin
            next_vol = volatile_s'(`VOLATILE_RESET);
        end else if (avs_write && !avs_waitrequest &&
                     avs_address == `REG_VOLATILE) begin
            next_vol = volatile_s'(avs_writedata[`VOLATILE_MSB:0]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            armed <= 1'b0;
            recover_cnt <= 16'h0000;
            reset_count <= `RESET_COUNT_RESET;
            op_abort <= 1'b0;
            vol <= volatile_s'(`VOLATILE_RESET);
        end else begin
            armed <= next_armed;
            recover_cnt <= next_recover_cnt;
            reset_count <= next_reset_count;
            op_abort <= next_op_abort;
            vol <= next_vol;
        end
    end

    // Avalon slave: every access is answered one cycle after it appears,
    // with a single low cycle of waitrequest.
    logic next_avs_waitrequest;
    logic [31:0] next_avs_readdata;

    always_comb begin
        next_avs_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
        next_avs_readdata = avs_readdata;
        if (avs_read && avs_waitrequest) begin
            next_avs_readdata = 32'h0000_0000;
            if (avs_address == `REG_STATUS) begin
                next_avs_readdata[`STATUS_RECOVER_BIT] = recover_busy;
                next_avs_readdata[`STATUS_ARMED_BIT] = armed;
                next_avs_readdata[`STATUS_READING_BIT] = state == st_data;
                next_avs_readdata[`STATUS_OP_BUSY_BIT] = op_busy;
                next_avs_readdata[`STATUS_COUNT_MSB:`STATUS_COUNT_LSB] =
                    reset_count;
            end else if (avs_address == `REG_VOLATILE) begin
                next_avs_readdata[`VOLATILE_MSB:0] = vol;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `READDATA_RESET;
        end else begin
            avs_waitrequest <= next_avs_waitrequest;
            avs_readdata <= next_avs_readdata;
        end
    end

    a_reset_clears: assert property (
        reset_go |=> (vol == volatile_s'(`VOLATILE_RESET)) && op_abort)
        else $error("volatile state not cleared by reset");
    a_recover_ignores: assert property (
        (state == st_opcode && sclk_rise && bit_cnt == 5'd7 && recover_busy)
        |=> state == st_ignore)
        else $error("command accepted during reset recovery");
    a_recover_holds: assert property (
        reset_go |=> recover_busy [*8])
        else $error("reset recovery ended too early");
    a_reset_needs_enable: assert property (
        (cs_rise && clean_frame && opcode == `OP_RESET && !armed)
        |=> !op_abort)
        else $error("reset taken without enable");
    a_enable_cancel: assert property (
        (cs_rise && op_done && opcode != `OP_RESET_ENABLE && !reset_go)
        |=> !armed)
        else $error("enable survived another frame");
    a_sig_bytes: assert property (
        (tbl_addr == 24'h00_0000 |-> table_byte == 8'h53) and
        (tbl_addr == 24'h00_0006 |-> table_byte == 8'h01))
        else $error("signature or header count wrong");
    a_unused_ff: assert property (
        (tbl_addr == 24'h00_0007 || tbl_addr == 24'h00_000F ||
         tbl_addr == 24'h00_0017) |-> table_byte == 8'hFF)
        else $error("unused header byte not FFh");
    a_header_lengths: assert property (
        (tbl_addr == 24'h00_000B |-> table_byte == 8'h09) and
        (tbl_addr == 24'h00_0013 |-> table_byte == 8'h03) and
        (tbl_addr == 24'h00_0014 |-> table_byte == 8'h60))
        else $error("parameter header wrong");
    a_std_bytes: assert property (
        (tbl_addr == 24'h00_0030 |-> table_byte == 8'hE5) and
        (tbl_addr == 24'h00_0031 |-> table_byte == 8'h20) and
        (tbl_addr == 24'h00_0032 |-> table_byte == 8'hF1))
        else $error("standard table bytes 30h-32h wrong");
    a_fast_reads: assert property (
        (tbl_addr == 24'h00_0038 |-> table_byte == 8'h44) and
        (tbl_addr == 24'h00_0039 |-> table_byte == 8'hEB) and
        (tbl_addr == 24'h00_003B |-> table_byte == 8'h6B))
        else $error("fast read entries wrong");
    a_data_drive: assert property (
        (state == st_data && cs_low && sclk_fall)
        |=> !spi_so_oe_n && spi_so == $past(out_bit))
        else $error("data bit not driven");
    a_bus_answer: assert property (
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus access not answered in one cycle");
endmodule

// >>> spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    input wire logic sys_clk,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_si,
    input wire logic spi_so,
    input wire logic spi_so_oe_n
);
    logic [7:0] rx_q[$];
    int oe_bad = 0;
    int half = 5;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Head bits go out MSB first, then nread bytes are clocked in.
    // The clock stands low outside frames; an unused data line toggles.
    task automatic frame(input logic [39:0] head, input int nhead,
                         input int nread);
        logic [7:0] sh;
        rx_q.delete();
        spi_cs_n <= 1'b0;
        spi_si <= head[39];
        for (int i = 0; i < nhead + 8 * nread; i++) begin
            wait_clk(half);
            spi_sclk <= 1'b1;
            // A released line reads as the inverse of the last bit driven.
            sh = {sh[6:0], spi_so_oe_n ? ~spi_so : spi_so};
            if (spi_so_oe_n !== (i < nhead)) begin
                oe_bad++;
            end
            if (i >= nhead && (i - nhead) % 8 == 7) begin
                rx_q.push_back(sh);
            end
            wait_clk(half);
            spi_sclk <= 1'b0;
            spi_si <= (i + 1 < nhead) ? head[38 - i] : ~spi_si;
        end
        wait_clk(half);
        spi_cs_n <= 1'b1;
        spi_si <= ~spi_si;
        wait_clk(8);
    endtask
endmodule

// >>> serial_flash_reset_and_param_table_tb.sv
`timescale 1ns/1ps
`include "spi_param_defs.svh"
module serial_flash_reset_and_param_table_tb;
    localparam int RST_N = 400;
    // The vendor byte is arbitrary.
    localparam logic [7:0] VID = 8'hA7;
    localparam logic [191:0] HDR = {32'h5346_4450, 32'h0001_01FF,
        32'h0000_0109, 32'h3000_00FF, VID, 24'h00_0103, 32'h6000_00FF};
    localparam logic [95:0] STD = {32'hE520_F1FF, 32'hFFFF_3F00,
        32'h44EB_086B};
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic spi_sclk;
    logic spi_cs_n;
    logic spi_si;
    logic spi_so;
    logic spi_so_oe_n;
    logic op_busy = 1'b0;
    logic op_abort;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int n_mismatch = 0;
    int check_count = 0;
    int n_abort = 0;
    int seed = 32'h87cd_f3c0;
    logic [20:0] vol;
    logic busy = 1'b0;
    logic [31:0] q;

    always #25 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (op_abort === 1'b1) begin
            n_abort++;
        end
    end

    serial_flash_reset_and_param_table #(
        .RST_CYCLES(RST_N),
        .VENDOR_ID(VID)
    ) serial_flash_reset_and_param_table_inst (
        .sys_clk(sys_clk),
        .srst(srst),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_si(spi_si),
        .spi_so(spi_so),
        .spi_so_oe_n(spi_so_oe_n),
        .op_busy(op_busy),
        .op_abort(op_abort),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    spi_host_model spi_host_model_inst (
        .sys_clk(sys_clk),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_si(spi_si),
        .spi_so(spi_so),
        .spi_so_oe_n(spi_so_oe_n)
    );

    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        if (a < 24'h00_0018) begin
            return HDR[8 * (23 - a) +: 8];
        end
        if (a >= 24'h00_0030 && a < 24'h00_003C) begin
            return STD[8 * (59 - a) +: 8];
        end
        return 8'hFF;
    endfunction

    function automatic logic [31:0] st(input logic [7:0] c, input logic b,
                                       input logic arm, input logic rec);
        return {16'h0000, c, 4'h0, b, 1'b0, arm, rec};
    endfunction

    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: word %h, want %h", $time, got, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask

    // The request is held until waitrequest is seen low at an edge.
    task automatic avs_xfer(input logic wr, input logic [3:0] a,
                            input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            n_mismatch++;
            $display("wrong value at %0t: bus answer timed out", $time);
        end
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        avs_xfer(1'b0, a, 32'h0000_0000, q);
        chk32(q, e);
    endtask

    task automatic cmd(input logic [7:0] op, input int n);
        spi_host_model_inst.frame({op, 32'h0000_0000}, n, 0);
    endtask

    task automatic tbl(input logic [23:0] a, input int n);
        spi_host_model_inst.frame({`OP_PARAM_READ, a, 8'h00}, 40, n);
        for (int i = 0; i < n; i++) begin
            chk8(spi_host_model_inst.rx_q[i], exp_byte(a + 24'(i)));
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            avs_xfer(1'b0, `REG_STATUS, 32'h0000_0000, q);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        if (q[0] !== 1'b0) begin
            n_mismatch++;
            $display("wrong value at %0t: recovery never ended", $time);
        end
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(`REG_STATUS, st(8'h00, 1'b0, 1'b0, 1'b0));
        rd(`REG_VOLATILE, 32'h0000_0000);
        rd(4'hC, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            vol = 21'($random(seed)) | 21'h00_0001;
            busy = 1'($random(seed));
            op_busy <= busy;
            avs_xfer(1'b1, `REG_VOLATILE, {11'h000, vol}, q);
            avs_xfer(1'b1, `REG_STATUS, $random(seed), q);
            rd(`REG_VOLATILE, {11'h000, vol});
            rd(`REG_STATUS, st(8'h00, busy, 1'b0, 1'b0));
        end
        tbl(24'h00_0000, 24);
        tbl(24'h00_0030, 12);
        for (int k = 0; k < 4; k++) begin
            tbl(24'({$random(seed)} % 56), 4);
        end
        cmd(`OP_RESET_ENABLE, 8);
        rd(`REG_STATUS, st(8'h00, busy, 1'b1, 1'b0));
        tbl(24'h00_0007, 1);
        cmd(`OP_RESET, 8);
        cmd(`OP_RESET_ENABLE, 8);
        cmd(`OP_RESET, 4);
        cmd(`OP_RESET, 8);
        rd(`REG_VOLATILE, {11'h000, vol});
        chk32(n_abort, 32'h0000_0000);
        rd(`REG_STATUS, st(8'h00, busy, 1'b0, 1'b0));
        cmd(`OP_RESET_ENABLE, 8);
        cmd(`OP_RESET, 8);
        rd(`REG_STATUS, st(8'h01, busy, 1'b0, 1'b1));
        cmd(`OP_RESET_ENABLE, 8);
        cmd(`OP_RESET, 8);
        wait_idle();
        rd(`REG_STATUS, st(8'h01, busy, 1'b0, 1'b0));
        rd(`REG_VOLATILE, 32'h0000_0000);
        chk32(n_abort, 32'h0000_0001);
        avs_xfer(1'b1, `REG_VOLATILE, {11'h000, vol}, q);
        cmd(`OP_RESET_ENABLE, 8);
        cmd(`OP_RESET, 8);
        wait_idle();
        rd(`REG_VOLATILE, 32'h0000_0000);
        avs_xfer(1'b1, `REG_VOLATILE, {11'h000, vol}, q);
        avs_xfer(1'b1, `REG_CTRL, 32'h0000_0001, q);
        rd(`REG_CTRL, 32'h0000_0000);
        wait_idle();
        rd(`REG_STATUS, st(8'h03, busy, 1'b0, 1'b0));
        rd(`REG_VOLATILE, 32'h0000_0000);
        chk32(n_abort, 32'h0000_0003);
        tbl(24'h00_0010, 8);
        chk32(spi_host_model_inst.oe_bad, 32'h0000_0000);
        stop_test();
    end
endmodule
